// *** rtl/ac_pkg.sv ***
package ac_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int LVL_W  = 10;
	localparam int CC_W   = 20;
	localparam int DATA_W = 20;
	localparam int NCMP   = 2;

	// ****************************************
	// register selection on the write port
	// ****************************************
	typedef enum logic [3:0] {
		SEL_MAIN,
		SEL_COMPARATOR_ZERO,
		SEL_COMPARATOR_ONE,
		SEL_WIN,
		SEL_EVENT,
		SEL_SECOND,
		SEL_FLAG,
		SEL_INTEN,
		SEL_DEBUG
	} reg_sel_t;

	// ****************************************
	// main control register fields
	// ****************************************
	localparam int MAIN_SOFT_RESET_BIT = 0;
	localparam int MAIN_EN    = 1;

	// ****************************************
	// comparator control register fields
	// ****************************************
	localparam int CC_EN      = 0;
	localparam int CC_SINGLE  = 1;
	localparam int CC_INTSEL  = 2;
	localparam int CC_MUXNEG  = 4;
	localparam int CC_MUXPOS  = 8;
	localparam int CC_FLEN    = 10;
	localparam int CC_OUTSEL  = 12;
	localparam int CC_SCALE   = 14;
	localparam logic [CC_W-1:0] CC_RESET = 20'h0_0000;

	// interrupt selections
	localparam logic [1:0] INT_TOGGLE = 2'h0;
	localparam logic [1:0] INT_RISE   = 2'h1;
	localparam logic [1:0] INT_FALL   = 2'h2;
	localparam logic [1:0] INT_EOC    = 2'h3;

	// negative input selections; 0 to 3 are the shared pins
	localparam logic [2:0] NEG_GND     = 3'h4;
	localparam logic [2:0] NEG_BANDGAP = 3'h5;
	localparam logic [2:0] NEG_SCALER  = 3'h6;
	localparam logic [2:0] NEG_DAC     = 3'h7;

	// filter lengths
	localparam logic [1:0] FLT_OFF  = 2'h0;
	localparam logic [1:0] FLT_MAJ3 = 2'h1;
	localparam logic [1:0] FLT_MAJ5 = 2'h2;

	// pin output selections
	localparam logic [1:0] OUT_OFF   = 2'h0;
	localparam logic [1:0] OUT_ASYNC = 2'h1;
	localparam logic [1:0] OUT_SYNC  = 2'h2;

	// ****************************************
	// window control fields
	// ****************************************
	localparam int WIN_EN  = 0;
	localparam int WIN_SEL = 1;
	localparam logic [1:0] WSEL_ABOVE   = 2'h0;
	localparam logic [1:0] WSEL_INSIDE  = 2'h1;
	localparam logic [1:0] WSEL_BELOW   = 2'h2;
	localparam logic [1:0] WSEL_OUTSIDE = 2'h3;

	// ****************************************
	// event control fields
	// ****************************************
	localparam int EV_COMPO = 0;
	localparam int EV_WINO  = 2;
	localparam int EV_COMPI = 3;

	// interrupt flag / enable bit positions
	localparam int FLAG_WIN = 2;

	// ****************************************
	// timing
	// ****************************************
	localparam logic [3:0] SAMPLE_DIV    = 4'h4;
	localparam logic [3:0] STARTUP_TICKS = 4'h2;
	localparam int SCALE_SHIFT = 6;

	typedef enum {
		PH_IDLE,
		PH_START,
		PH_RUN
	} phase_t;

endpackage

// *** rtl/analog_comparator_control.sv ***
`timescale 1ns/1ps
// Behaviour
// - output high only when positive exceeds negative
// - two identical comparators, own control registers
// - independent use or paired window mode
// - global enable bit enables/disables block
// - soft reset restores all registers, disables
// - comparator runs with both enables; bits kept
// - outputs sampled at digital sampling clock rate
// - certain writes synchronized to sampling domain
// - write protection except secondary, flags, debugger
// - runs in debug unless configured to halt
// - keeps running in sleep, events don't wake
// - interrupt requests can wake from sleep
// - interrupt on rise, fall, toggle, end
// - window interrupts above, inside, below, outside
// - events from comparator states and window status
// - optional digital filter before interrupts/events
// - comparator state routable to pin, async/sync
// - four pins, ground, bandgap, scaler, converter inputs
// - edges found by comparing current and previous sample
// - comparator settings frozen while comparator enabled
module analog_comparator_control (
	input  wire logic                                mclk,
	input  wire logic                                rst,
	input  wire logic                                reg_wr,
	input  wire logic [3:0]                          reg_sel,
	input  wire logic [ac_pkg::DATA_W-1:0]           reg_wdata,
	input  wire logic                                wp_on,
	input  wire logic                                dbg_access,
	input  wire logic                                dbg_halted,
	input  wire logic                                sleep_mode,
	input  wire logic [1:0]                          evt_start,
	input  wire logic [3:0][ac_pkg::LVL_W-1:0]       ain_level,
	input  wire logic [ac_pkg::LVL_W-1:0]            bandgap_level,
	input  wire logic [ac_pkg::LVL_W-1:0]            dac_level,
	input  wire logic [ac_pkg::LVL_W-1:0]            vdd_level,
	output logic                                     enabled,
	output logic [1:0]                               comp_state,
	output logic [1:0]                               comp_ready,
	output logic                                     win_inside,
	output logic                                     win_above,
	output logic [2:0]                               int_flags,
	output logic                                     sync_busy,
	output logic                                     irq,
	output logic                                     wake_req,
	output logic [1:0]                               comparator_output_pin,
	output logic [1:0]                               evt_comp,
	output logic                                     evt_win
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [ac_pkg::LVL_W-1:0] neg_level(
		input logic [2:0]                     sel,
		input logic [5:0]                     scale,
		input logic [3:0][ac_pkg::LVL_W-1:0]  pins,
		input logic [ac_pkg::LVL_W-1:0]       bg,
		input logic [ac_pkg::LVL_W-1:0]       dac,
		input logic [ac_pkg::LVL_W-1:0]       vdd
	);
		logic [16:0] prod;
		prod = 17'(vdd) * 17'({1'b0, scale} + 7'h01);
		case (sel)
			ac_pkg::NEG_GND:     neg_level = '0;
			ac_pkg::NEG_BANDGAP: neg_level = bg;
			ac_pkg::NEG_SCALER:  neg_level = prod[ac_pkg::SCALE_SHIFT +: ac_pkg::LVL_W];
			ac_pkg::NEG_DAC:     neg_level = dac;
			default:             neg_level = pins[sel[1:0]];
		endcase
	endfunction

	function automatic logic majority(input logic [4:0] h, input logic [1:0] flen);
		logic [2:0] ones;
		ones = 3'(h[0]) + 3'(h[1]) + 3'(h[2]) + 3'(h[3]) + 3'(h[4]);
		case (flen)
			ac_pkg::FLT_MAJ3: majority = (h[0] & h[1]) | (h[1] & h[2]) | (h[0] & h[2]);
			ac_pkg::FLT_MAJ5: majority = ones >= 3'h3;
			default:          majority = h[0];
		endcase
	endfunction

	// ****************************************
	// configuration state
	// ****************************************
	logic                    en_q;
	logic [ac_pkg::CC_W-1:0] cc_q [2];
	logic [2:0]              win_q;
	logic [4:0]              ev_q;
	logic [2:0]              mask_q;
	logic                    dbg_halt_q;
	logic                    pend_en_q;
	logic                    pend_en_val_q;
	logic [1:0]              pend_cc_q;
	logic [ac_pkg::CC_W-1:0] pend_cc_val_q [2];
	logic [1:0]              start_q;
	logic [2:0]              flags_q;

	logic [3:0]              div_q;
	logic                    tick;
	logic                    wr_ok;
	logic                    srst;
	logic [1:0]              raw;
	logic [1:0]              run;
	logic [1:0]              start_wr;

	// protection is bypassed for the debugger
	// protection gate
	assign wr_ok = reg_wr & (~wp_on | dbg_access);
	assign srst  = rst | (wr_ok && reg_sel == ac_pkg::SEL_MAIN && reg_wdata[ac_pkg::MAIN_SOFT_RESET_BIT]);
	assign start_wr = (reg_wr && reg_sel == ac_pkg::SEL_SECOND) ? reg_wdata[1:0] : 2'h0;

	// ****************************************
	// sampling enable divider
	// ****************************************
	// sample rate tick
	always_ff @(posedge mclk) begin
		if (rst || div_q == ac_pkg::SAMPLE_DIV - 4'h1) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end
	assign tick = (div_q == ac_pkg::SAMPLE_DIV - 4'h1);

	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge mclk) begin
		if (srst) begin
			en_q          <= 1'b0;
			pend_en_q     <= 1'b0;
			pend_en_val_q <= 1'b0;
			pend_cc_q     <= '0;
			win_q         <= '0;
			ev_q          <= '0;
			mask_q        <= '0;
			dbg_halt_q    <= 1'b0;
			for (int i = 0; i < ac_pkg::NCMP; i++) begin
				cc_q[i]          <= ac_pkg::CC_RESET;
				pend_cc_val_q[i] <= ac_pkg::CC_RESET;
			end
		end else begin
			// enable and comparator settings land on a sampling tick
			// apply synchronized writes
			if (tick) begin
				if (pend_en_q) begin
					en_q      <= pend_en_val_q;
					pend_en_q <= 1'b0;
				end
				for (int i = 0; i < ac_pkg::NCMP; i++) begin
					if (pend_cc_q[i]) begin
						cc_q[i]      <= pend_cc_val_q[i];
						pend_cc_q[i] <= 1'b0;
					end
				end
			end
			if (wr_ok) begin
				case (reg_sel)
					ac_pkg::SEL_MAIN: begin
						pend_en_q     <= 1'b1;
						pend_en_val_q <= reg_wdata[ac_pkg::MAIN_EN];
					end
					ac_pkg::SEL_COMPARATOR_ZERO, ac_pkg::SEL_COMPARATOR_ONE: begin
						for (int i = 0; i < ac_pkg::NCMP; i++) begin
							if (reg_sel == 4'(ac_pkg::SEL_COMPARATOR_ZERO) + 4'(i)) begin
								pend_cc_q[i] <= 1'b1;
								if (cc_q[i][ac_pkg::CC_EN]) begin
									pend_cc_val_q[i] <= cc_q[i];
									pend_cc_val_q[i][ac_pkg::CC_EN] <=
										reg_wdata[ac_pkg::CC_EN];
								end else begin
									pend_cc_val_q[i] <= reg_wdata[ac_pkg::CC_W-1:0];
								end
							end
						end
					end
					ac_pkg::SEL_WIN: begin
						win_q <= reg_wdata[2:0];
					end
					ac_pkg::SEL_EVENT: begin
						if (!en_q && !(pend_en_q && pend_en_val_q)) begin
							ev_q <= reg_wdata[4:0];
						end
					end
					ac_pkg::SEL_INTEN: begin
						mask_q <= reg_wdata[2:0];
					end
					ac_pkg::SEL_DEBUG: begin
						dbg_halt_q <= reg_wdata[0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ****************************************
	// analog front end model
	// ****************************************
	always_comb begin
		for (int i = 0; i < ac_pkg::NCMP; i++) begin
			raw[i] = ain_level[cc_q[i][ac_pkg::CC_MUXPOS +: 2]] >
				neg_level(cc_q[i][ac_pkg::CC_MUXNEG +: 3], cc_q[i][ac_pkg::CC_SCALE +: 6],
					ain_level, bandgap_level, dac_level, vdd_level);
			run[i] = en_q & cc_q[i][ac_pkg::CC_EN] & ~(dbg_halted & dbg_halt_q);
		end
	end

	// ****************************************
	// comparator sequencing
	// ****************************************
	ac_pkg::phase_t phase_q [2];
	logic [3:0]     cnt_q   [2];
	logic [4:0]     hist_q  [2];
	logic [1:0]     state_q;
	logic [1:0]     prev_q;
	logic [1:0]     done_q;
	logic [1:0]     ready_q;
	logic [4:0]     hnext   [2];
	logic [1:0]     filt;

	always_comb begin
		for (int i = 0; i < ac_pkg::NCMP; i++) begin
			hnext[i] = {hist_q[i][3:0], raw[i]};
			filt[i]  = majority(hnext[i], cc_q[i][ac_pkg::CC_FLEN +: 2]);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= '0;
			prev_q  <= '0;
			done_q  <= '0;
			ready_q <= '0;
			start_q <= '0;
			for (int i = 0; i < ac_pkg::NCMP; i++) begin
				phase_q[i] <= ac_pkg::PH_IDLE;
				cnt_q[i]   <= '0;
				hist_q[i]  <= '0;
			end
		end else begin
			done_q <= '0;
			for (int i = 0; i < ac_pkg::NCMP; i++) begin
				// a start request waits for the next sampling tick
				if (start_wr[i] || (evt_start[i] && ev_q[ac_pkg::EV_COMPI + i])) begin
					start_q[i] <= 1'b1;
					ready_q[i] <= 1'b0;
				end
				if (!run[i] && !(dbg_halted && dbg_halt_q)) begin
					phase_q[i] <= ac_pkg::PH_IDLE;
					ready_q[i] <= 1'b0;
					start_q[i] <= 1'b0;
				end else if (tick && run[i]) begin
					hist_q[i] <= hnext[i];
					case (phase_q[i])
						ac_pkg::PH_IDLE: begin
							cnt_q[i] <= '0;
							if (!cc_q[i][ac_pkg::CC_SINGLE] || start_q[i]) begin
								phase_q[i] <= ac_pkg::PH_START;
								start_q[i] <= 1'b0;
							end
						end
						ac_pkg::PH_START: begin
							cnt_q[i] <= cnt_q[i] + 4'h1;
							if (cnt_q[i] == ac_pkg::STARTUP_TICKS - 4'h1) begin
								prev_q[i]  <= state_q[i];
								state_q[i] <= filt[i];
								done_q[i]  <= 1'b1;
								ready_q[i] <= 1'b1;
								phase_q[i] <= cc_q[i][ac_pkg::CC_SINGLE] ?
									ac_pkg::PH_IDLE : ac_pkg::PH_RUN;
							end
						end
						ac_pkg::PH_RUN: begin
							prev_q[i]  <= state_q[i];
							state_q[i] <= filt[i];
							done_q[i]  <= 1'b1;
						end
						default: begin
							phase_q[i] <= ac_pkg::PH_IDLE;
						end
					endcase
				end
			end
		end
	end

	// ****************************************
	// window status
	// ****************************************
	// comparator zero watches the upper bound, comparator one the lower
	logic w_above;
	logic w_below;
	logic w_inside;
	assign w_above  = state_q[0];
	assign w_below  = ~state_q[1];
	assign w_inside = ~w_above & ~w_below;

	// ****************************************
	// interrupt flags and events
	// ****************************************
	logic [2:0] hit;
	logic       win_hit;

	always_comb begin
		for (int i = 0; i < ac_pkg::NCMP; i++) begin
			case (cc_q[i][ac_pkg::CC_INTSEL +: 2])
				ac_pkg::INT_RISE:   hit[i] = done_q[i] & state_q[i] & ~prev_q[i];
				ac_pkg::INT_FALL:   hit[i] = done_q[i] & ~state_q[i] & prev_q[i];
				ac_pkg::INT_EOC:    hit[i] = done_q[i];
				default:            hit[i] = done_q[i] & (state_q[i] ^ prev_q[i]);
			endcase
		end
		case (win_q[ac_pkg::WIN_SEL +: 2])
			ac_pkg::WSEL_ABOVE:  win_hit = w_above;
			ac_pkg::WSEL_INSIDE: win_hit = w_inside;
			ac_pkg::WSEL_BELOW:  win_hit = w_below;
			default:             win_hit = ~w_inside;
		endcase
		hit[ac_pkg::FLAG_WIN] = win_q[ac_pkg::WIN_EN] & (|done_q) & win_hit;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			flags_q <= '0;
		end else if (reg_wr && reg_sel == ac_pkg::SEL_FLAG) begin
			// new events win over a write-one clear
			flags_q <= (flags_q & ~reg_wdata[2:0]) | hit;
		end else begin
			flags_q <= flags_q | hit;
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge mclk) begin
		if (srst) begin
			enabled               <= 1'b0;
			comp_state            <= '0;
			comp_ready            <= '0;
			win_inside            <= 1'b0;
			win_above             <= 1'b0;
			int_flags             <= '0;
			sync_busy             <= 1'b0;
			irq                   <= 1'b0;
			wake_req              <= 1'b0;
			comparator_output_pin <= '0;
			evt_comp              <= '0;
			evt_win               <= 1'b0;
		end else begin
			enabled    <= en_q;
			comp_state <= state_q;
			comp_ready <= ready_q;
			win_inside <= w_inside;
			win_above  <= w_above;
			int_flags  <= flags_q;
			sync_busy  <= pend_en_q | (|pend_cc_q);
			irq        <= |(flags_q & mask_q);
			wake_req   <= sleep_mode & (|(flags_q & mask_q));
			for (int i = 0; i < ac_pkg::NCMP; i++) begin
				case (cc_q[i][ac_pkg::CC_OUTSEL +: 2])
					ac_pkg::OUT_ASYNC: comparator_output_pin[i] <= raw[i] & run[i];
					ac_pkg::OUT_SYNC:  comparator_output_pin[i] <= state_q[i];
					default:           comparator_output_pin[i] <= 1'b0;
				endcase
				evt_comp[i] <= done_q[i] & state_q[i] & ev_q[ac_pkg::EV_COMPO + i];
			end
			evt_win <= (|done_q) & win_q[ac_pkg::WIN_EN] & w_inside & ev_q[ac_pkg::EV_WINO];
		end
	end

endmodule

// *** verif/ac_checker_asserts.sv ***
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module ac_checker (
	input wire logic                      mclk,
	input wire logic                      rst,
	input wire logic                      reg_wr,
	input wire logic [3:0]                reg_sel,
	input wire logic [ac_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                      wp_on,
	input wire logic                      dbg_access,
	input wire logic                      sleep_mode,
	input wire logic                      enabled,
	input wire logic [1:0]                comp_state,
	input wire logic [2:0]                int_flags,
	input wire logic                      sync_busy,
	input wire logic                      irq,
	input wire logic                      wake_req,
	input wire logic [1:0]                evt_comp,
	input wire logic                      evt_win,
	input wire logic                      win_inside,
	input wire logic                      win_above
);
	logic main_wr;
	logic prot_wr;

	assign main_wr = reg_wr && reg_sel == ac_pkg::SEL_MAIN && (!wp_on || dbg_access);
	assign prot_wr = reg_wr && reg_sel == ac_pkg::SEL_MAIN && wp_on && !dbg_access;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_reset_quiet: assert property ($fell(rst) |-> !enabled && int_flags == 3'h0 && !irq)
		else $error("outputs not idle after reset");
	a_soft_reset_bit_clear: assert property (main_wr && reg_wdata[0] |=> !enabled && int_flags == 3'h0 && !sync_busy)
		else $error("soft reset left state behind");
	// a dropped write must not sneak in through the synchroniser later
	a_prot_drop: assert property (prot_wr && !enabled && !sync_busy |=> !enabled [*8])
		else $error("protected write took effect");
	a_enable_lat: assert property (main_wr && reg_wdata[1:0] == 2'h2 |-> ##[1:6] enabled)
		else $error("enable not applied in time");
	a_disable_lat: assert property (main_wr && !reg_wdata[1] |-> ##[1:6] !enabled)
		else $error("disable not applied in time");
	a_busy_bound: assert property ($rose(sync_busy) |-> ##[1:10] !sync_busy)
		else $error("sync busy stuck");
	a_evt_zero: assert property (evt_comp[0] |=> comp_state[0] && !evt_comp[0])
		else $error("comparator zero event without high state");
	a_evt_one: assert property (evt_comp[1] |=> comp_state[1] && !evt_comp[1])
		else $error("comparator one event without high state");
	a_irq_cause: assert property (irq |-> int_flags != 3'h0 || $past(int_flags) != 3'h0)
		else $error("interrupt without flag");
	a_wake_sleep: assert property (wake_req |-> (irq || $past(irq)) && (sleep_mode || $past(sleep_mode)))
		else $error("wake request without sleeping interrupt");
	a_win_excl: assert property (win_inside |-> !win_above)
		else $error("inside and above together");
	a_win_evt: assert property (evt_win |-> win_inside)
		else $error("window event while not inside");
endmodule

bind analog_comparator_control ac_checker ac_checker_i (
	.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
	.wp_on(wp_on), .dbg_access(dbg_access), .sleep_mode(sleep_mode), .enabled(enabled),
	.comp_state(comp_state), .int_flags(int_flags), .sync_busy(sync_busy), .irq(irq),
	.wake_req(wake_req), .evt_comp(evt_comp), .evt_win(evt_win),
	.win_inside(win_inside), .win_above(win_above)
);

// *** verif/analog_comparator_control_test.sv ***
`timescale 1ns/1ps
module analog_comparator_control_test;
	logic                            mclk;
	logic                            rst;
	logic                            reg_wr;
	logic [3:0]                      reg_sel;
	logic [ac_pkg::DATA_W-1:0]       reg_wdata;
	logic                            wp_on;
	logic                            dbg_access;
	logic                            dbg_halted;
	logic                            sleep_mode;
	logic [1:0]                      evt_start;
	logic [3:0][ac_pkg::LVL_W-1:0]   ain_level;
	logic [ac_pkg::LVL_W-1:0]        bandgap_level;
	logic [ac_pkg::LVL_W-1:0]        dac_level;
	logic [ac_pkg::LVL_W-1:0]        vdd_level;
	logic                            enabled;
	logic [1:0]                      comp_state;
	logic [1:0]                      comp_ready;
	logic                            win_inside;
	logic                            win_above;
	logic [2:0]                      int_flags;
	logic                            sync_busy;
	logic                            irq;
	logic                            wake_req;
	logic [1:0]                      comparator_output_pin;
	logic [1:0]                      evt_comp;
	logic                            evt_win;
	logic                            s0;
	logic                            s1;
	logic                            wi;
	logic [3:0]                      wv;
	int                              num_errors = 0;
	int                              checks_done = 0;
	int                              seed;
	int                              c;
	int                              st;
	int                              v;
	int                              e;

	analog_comparator_control analog_comparator_control_i (
		.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
		.wp_on(wp_on), .dbg_access(dbg_access), .dbg_halted(dbg_halted),
		.sleep_mode(sleep_mode), .evt_start(evt_start), .ain_level(ain_level),
		.bandgap_level(bandgap_level), .dac_level(dac_level), .vdd_level(vdd_level),
		.enabled(enabled), .comp_state(comp_state), .comp_ready(comp_ready),
		.win_inside(win_inside), .win_above(win_above), .int_flags(int_flags),
		.sync_busy(sync_busy), .irq(irq), .wake_req(wake_req),
		.comparator_output_pin(comparator_output_pin), .evt_comp(evt_comp), .evt_win(evt_win)
	);

	// ****************************************
	// reference model and bus helpers
	// ****************************************
	function automatic int lvl(int s, int k);
		case (s)
			4: return 0;
			5: return bandgap_level;
			6: return (vdd_level * (k + 1)) >> 6;
			7: return dac_level;
			default: return ain_level[s];
		endcase
	endfunction

	function automatic logic [19:0] cw(logic [1:0] is, logic [2:0] ng, logic [1:0] ps,
		logic [1:0] fl, logic [5:0] k);
		return {k, ac_pkg::OUT_SYNC, fl, ps, 1'b0, ng, is, 2'h1};
	endfunction

	task automatic chk(string n, logic [31:0] s, logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask

	task automatic wr(ac_pkg::reg_sel_t r, logic [19:0] d, logic wp = 1'b0, logic db = 1'b0);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_sel <= r;
		reg_wdata <= d;
		wp_on <= wp;
		dbg_access <= db;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic settle();
		repeat (40) @(posedge mclk);
		#1;
	endtask

	// settings of a running comparator are frozen, so stop it and let the stop land first
	task automatic cfg(int n, logic [19:0] d);
		wr(ac_pkg::reg_sel_t'(1 + n), 20'h0_0000);
		settle();
		wr(ac_pkg::reg_sel_t'(1 + n), d);
		settle();
	endtask

	task automatic pin(int i, int x);
		@(posedge mclk);
		ain_level[i] <= 10'(x);
	endtask

	task automatic count();
		e = 0;
		st = 0;
		repeat (40) begin
			@(posedge mclk);
			#1;
			e += evt_comp[0];
			st += evt_win;
		end
	endtask

	task automatic test_done();
		if (num_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ****************************************
	// clock, watchdog and sequence
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	initial begin
		repeat (30000) @(posedge mclk);
		num_errors++;
		test_done();
	end

	initial begin
		seed = 2108;
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_sel = 4'h0;
		reg_wdata = 20'h0_0000;
		wp_on = 1'b0;
		dbg_access = 1'b0;
		dbg_halted = 1'b0;
		sleep_mode = 1'b0;
		evt_start = 2'h0;
		ain_level = '0;
		bandgap_level = 10'h000;
		dac_level = 10'h000;
		vdd_level = 10'h000;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		chk("idle", {enabled, comp_state, comp_ready, int_flags, irq, evt_comp, sync_busy}, 0);
		wr(ac_pkg::SEL_MAIN, 20'h0_0002, 1'b1);
		settle();
		chk("enabled", enabled, 0);
		wr(ac_pkg::SEL_MAIN, 20'h0_0002, 1'b1, 1'b1);
		settle();
		chk("enabled", enabled, 1);
		for (int k = 0; k < 8; k++) begin
			c = k % 2;
			st = $random(seed) & 63;
			@(posedge mclk);
			for (int i = 0; i < 4; i++) ain_level[i] <= 10'($random(seed));
			bandgap_level <= 10'($random(seed));
			dac_level <= 10'($random(seed));
			vdd_level <= 10'($random(seed));
			// comparator one takes the asynchronous pin version
			cfg(c, cw(2'h0, 3'(k), 2'(k), 2'h0, 6'(st)) ^ (c ? 20'h0_3000 : 20'h0_0000));
			e = lvl(k % 4, st) > lvl(k, st);
			chk("state", comp_state[c], e);
			chk("ready", comp_ready[c], 1);
			chk("pin", comparator_output_pin[c], e);
		end
		pin(0, 500);
		pin(1, 200);
		cfg(0, cw(2'h0, 3'h1, 2'h0, 2'h0, 6'h00));
		@(posedge mclk);
		dac_level <= 10'h3ff;
		wr(ac_pkg::SEL_COMPARATOR_ZERO, cw(2'h0, ac_pkg::NEG_DAC, 2'h0, 2'h0, 6'h00));
		settle();
		chk("state", comp_state[0], 1);
		wr(ac_pkg::SEL_MAIN, 20'h0_0000);
		settle();
		chk("enabled", enabled, 0);
		pin(0, 100);
		wr(ac_pkg::SEL_MAIN, 20'h0_0002);
		settle();
		chk("state", comp_state[0], 0);
		chk("ready", comp_ready[0], 1);
		pin(0, 500);
		settle();
		wr(ac_pkg::SEL_EVENT, 20'h0_0003);
		count();
		chk("events", e, 0);
		wr(ac_pkg::SEL_MAIN, 20'h0_0000);
		settle();
		wr(ac_pkg::SEL_EVENT, 20'h0_001f);
		wr(ac_pkg::SEL_MAIN, 20'h0_0002);
		settle();
		count();
		chk("events", e, 10);
		@(posedge mclk);
		sleep_mode <= 1'b1;
		wr(ac_pkg::SEL_INTEN, 20'h0_0007);
		for (int m = 0; m < 4; m++) begin
			pin(0, 100);
			cfg(0, cw(2'(m), 3'h1, 2'h0, 2'(m % 3), 6'h00));
			wr(ac_pkg::SEL_FLAG, 20'h0_0007, 1'b1);
			settle();
			chk("flag", int_flags[0], m == 3);
			pin(0, 500);
			settle();
			chk("flag", int_flags[0], m != 2);
			chk("wake", wake_req, m != 2);
			wr(ac_pkg::SEL_FLAG, 20'h0_0007);
			pin(0, 100);
			settle();
			chk("flag", int_flags[0], m != 1);
		end
		@(posedge mclk);
		sleep_mode <= 1'b0;
		pin(1, 600);
		pin(2, 300);
		cfg(0, cw(2'h0, 3'h1, 2'h0, 2'h0, 6'h00));
		cfg(1, cw(2'h0, 3'h2, 2'h0, 2'h0, 6'h00));
		for (int k = 0; k < 12; k++) begin
			v = (k % 3) * 350 + 100;
			wr(ac_pkg::SEL_WIN, 20'(1 + 2 * (k / 3)));
			pin(0, v);
			settle();
			wr(ac_pkg::SEL_FLAG, 20'h0_0007);
			settle();
			s0 = v > 600;
			s1 = v > 300;
			wi = !s0 && s1;
			wv = {!wi, !s1, wi, s0};
			chk("inside", win_inside, wi);
			chk("above", win_above, s0);
			chk("wflag", int_flags[2], wv[k / 3]);
			count();
			chk("wevent", st, wi ? 10 : 0);
		end
		@(posedge mclk);
		dbg_halted <= 1'b1;
		pin(0, 100);
		settle();
		chk("state", comp_state[0], 0);
		wr(ac_pkg::SEL_DEBUG, 20'h0_0001);
		settle();
		pin(0, 800);
		settle();
		chk("state", comp_state[0], 0);
		@(posedge mclk);
		dbg_halted <= 1'b0;
		settle();
		chk("state", comp_state[0], 1);
		// single shot: started once by the start bit, once by an incoming event
		cfg(0, cw(2'h3, 3'h1, 2'h0, 2'h0, 6'h00) | 20'h0_0002);
		chk("ready", comp_ready[0], 0);
		wr(ac_pkg::SEL_SECOND, 20'h0_0001);
		settle();
		chk("ready", comp_ready[0], 1);
		chk("state", comp_state[0], 1);
		pin(0, 100);
		wr(ac_pkg::SEL_FLAG, 20'h0_0007);
		settle();
		chk("flag", int_flags[0], 0);
		@(posedge mclk);
		evt_start <= 2'h1;
		@(posedge mclk);
		evt_start <= 2'h0;
		settle();
		chk("state", comp_state[0], 0);
		chk("flag", int_flags[0], 1);
		wr(ac_pkg::SEL_MAIN, 20'h0_0001);
		settle();
		chk("soft_reset_bit", {enabled, int_flags, comp_ready}, 0);
		wr(ac_pkg::SEL_MAIN, 20'h0_0002);
		settle();
		chk("ready", comp_ready, 0);
		test_done();
	end
endmodule
